/* File: common/scs_consts.svh */
// constants for the station corner turner and frame sequencer
`ifndef SCS_CONSTS_SVH
`define SCS_CONSTS_SVH
`define SCS_SAMPLE_NS 1080
`define SCS_CLK_NS 50
`define SCS_IN_W 12
`define SCS_CHAIN_W 16
`define SCS_OUT_W 8
`define SCS_PAD_W 16
`define SCS_WORD_W 64
`define SCS_SAMP_W 48
`define SCS_CHANS 192
`define SCS_GROUPS 48
`define SCS_GCH 4
`define SCS_TDEPTH 8
`define SCS_BURST 32
`define SCS_MIN_BURST 8
`define SCS_TIME_W 21
`define SCS_ADDR_W 28
`define SCS_PKT_SAMP 256
`define SCS_PKT_BURSTS 32
`define SCS_CSP_SAMP 2048
`define SCS_BLOCK_DEF 102
`define SCS_BLOCKS_INT 4
`define SCS_PRE_FRAC 4
`define SCS_FIFO_DEPTH 64
`endif

/* File: common/scs_pkg.sv */
// types shared by the corner turner design files
package scs_pkg;
    typedef enum logic {SCS_SEQ_IDLE, SCS_SEQ_READ} scs_seq_state_t;
    typedef enum logic [1:0] {SCS_ARB_NONE, SCS_ARB_WR, SCS_ARB_RD}
        scs_arb_t;
endpackage : scs_pkg

/* File: rtl/scs_rate_fifo.sv */
// rate-change fifo between corner turner buffer and memory write port
`timescale 1ns/1ps
`include "scs_consts.svh"
module scs_rate_fifo #(
    parameter int WIDTH = `SCS_WORD_W,
    parameter int DEPTH = `SCS_FIFO_DEPTH
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // fill side
    input wire logic s_valid,
    output logic s_ready,
    input wire logic [WIDTH-1:0] s_data,
    // drain side
    output logic m_valid,
    input wire logic m_ready,
    output logic [WIDTH-1:0] m_data,
    output logic [$clog2(DEPTH):0] count
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp_reg;
    logic [AW-1:0] rp_reg;
    logic [AW:0] cnt_reg;
    logic push;
    logic pop;

    assign s_ready = cnt_reg != (AW+1)'(DEPTH);
    assign m_valid = cnt_reg != '0;
    assign m_data = mem[rp_reg];
    assign count = cnt_reg;
    assign push = s_valid && s_ready;
    assign pop = m_valid && m_ready;

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp_reg] <= s_data;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wp_reg <= '0;
            rp_reg <= '0;
            cnt_reg <= '0;
        end else begin
            if (push) begin
                wp_reg <= wp_reg + 1'b1;
            end
            if (pop) begin
                rp_reg <= rp_reg + 1'b1;
            end
            cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : scs_rate_fifo

/* File: rtl/scs_cornerturner.sv */
// corner turner, write address generator and chain frame sequencer
// Summary of operation
// - input frames are one sample apart, 1080 ns; frame count gives time
// - final frames: 2048 samples, one channel, 8+8 bit requantized values
// - chain packets hold 256 samples by 4 channels, 16+16 bit values
// - frames per block is programmable, default 102
// - four overlapping blocks make one integration period
// - preload repeats previous block end, adds ceil(2 nf) frames
// - block starts stay exactly one block length (block_frames frames, default 102) apart
// - bursts are 32 words: 8 time samples by 4 channels
// - bursts are built only after 8 frames sit in the input buffer
// - every memory access is a burst of at least 8 beats
// - only 64 bits of each memory word are used
// - bursts pass a rate fifo so write data never gaps
// - write address comes from buffer state and input frame count
// - one arbitrated generic request port reaches the memory controller
// - sequencer issues reads: self-paced on first node, else per packet
// - packet header picks which stored data is read back
// - local beam is added to packet samples and forwarded
// - first node makes station frames without waiting for packets
// - burst words are read and summed one per beat, each word one channel sample
// - input samples are 12+12 bit complex per polarization
// - stored words hold a 48-bit sample, upper 16 bits zero
// - write bursts start on word addresses that are multiples of 32
// - each input frame holds 192 channel samples
// - time part of the address wraps in its 21-bit field
`timescale 1ns/1ps
`include "scs_consts.svh"
module scs_cornerturner
    import scs_pkg::*;
#(
    parameter int BLK_W = 10,
    parameter int PKT_PERIOD_CYC =
        (`SCS_SAMPLE_NS * `SCS_PKT_SAMP + `SCS_CLK_NS - 1) / `SCS_CLK_NS
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // configuration levels
    input wire logic first_node,
    input wire logic [BLK_W-1:0] block_frames,
    input wire logic preload_en,
    input wire logic [7:0] preload_x2,
    // tile beam input frames
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [`SCS_SAMP_W-1:0] in_data,
    // memory request port
    output logic mem_req_valid,
    input wire logic mem_req_ready,
    output logic mem_req_write,
    output logic [`SCS_ADDR_W-1:0] mem_req_addr,
    output logic [5:0] mem_req_len,
    // memory write data
    output logic mem_wvalid,
    input wire logic mem_wready,
    output logic [`SCS_WORD_W-1:0] mem_wdata,
    // memory read data
    input wire logic mem_rvalid,
    input wire logic [`SCS_WORD_W-1:0] mem_rdata,
    // chain packet in
    input wire logic pkt_hdr_valid,
    output logic pkt_hdr_ready,
    input wire logic [19:0] pkt_hdr_time,
    input wire logic [5:0] pkt_hdr_group,
    input wire logic [`SCS_WORD_W-1:0] pkt_data,
    // chain packet out
    output logic out_valid,
    output logic out_last,
    output logic [`SCS_WORD_W-1:0] out_data,
    output logic [31:0] out_q8,
    output logic [19:0] out_time,
    output logic [5:0] out_group,
    output logic [1:0] out_block_idx
);
    localparam int PCW = $clog2(PKT_PERIOD_CYC + 1);
    localparam logic [5:0] BURST_LEN = 6'(`SCS_BURST);
    localparam logic [7:0] LAST_CH = 8'(`SCS_CHANS - 1);
    localparam logic [5:0] LAST_G = 6'(`SCS_GROUPS - 1);
    localparam logic [2:0] LAST_T = 3'(`SCS_TDEPTH - 1);
    localparam logic [1:0] LAST_C = 2'(`SCS_GCH - 1);
    localparam logic [4:0] LAST_K = 5'(`SCS_PKT_BURSTS - 1);

    // input buffer: two halves of 8 frames, channel index padded to 8 bits
    logic [`SCS_SAMP_W-1:0] ibuf [2**12];
    logic [7:0] in_ch_reg;
    logic [31:0] in_frame_reg;
    logic [1:0] half_full_reg;
    logic [19:0] half_time_reg [2];
    logic in_ready_reg;
    logic in_take;
    logic frame_end;
    logic half_end;
    logic nxt_half;

    assign in_take = in_valid && in_ready_reg;
    assign frame_end = in_take && in_ch_reg == LAST_CH;
    assign half_end = frame_end && in_frame_reg[2:0] == LAST_T;
    assign nxt_half = in_frame_reg[3] ^ half_end;
    assign in_ready = in_ready_reg;

    always_ff @(posedge clk) begin
        if (in_take) begin
            // 12+12 per polarization, two polarizations
            ibuf[{in_frame_reg[3:0], in_ch_reg}] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            in_ch_reg <= '0;
            in_frame_reg <= '0;
        end else if (in_take) begin
            in_ch_reg <= frame_end ? 8'h00 : in_ch_reg + 8'h01;
            // frame count is the time base, one per 1080 ns
            in_frame_reg <= in_frame_reg + 32'(frame_end);
        end
    end

    // drain counter: group, time, channel, time outer in each burst
    logic [5:0] dr_g_reg;
    logic [2:0] dr_t_reg;
    logic [1:0] dr_c_reg;
    logic dr_half_reg;
    logic f_s_valid;
    logic f_s_ready;
    logic dr_take;
    logic dr_end;

    assign f_s_valid = half_full_reg[dr_half_reg];
    assign dr_take = f_s_valid && f_s_ready;
    assign dr_end = dr_take && dr_g_reg == LAST_G && dr_t_reg == LAST_T &&
        dr_c_reg == LAST_C;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            half_full_reg <= '0;
            half_time_reg[0] <= '0;
            half_time_reg[1] <= '0;
            in_ready_reg <= 1'b0;
        end else begin
            // writer and drain work on opposite halves
            if (dr_end) begin
                half_full_reg[dr_half_reg] <= 1'b0;
            end
            if (half_end) begin
                half_full_reg[in_frame_reg[3]] <= 1'b1;
                half_time_reg[in_frame_reg[3]] <=
                    {in_frame_reg[19:3], 3'h0};
            end
            // conservative: a freed half is seen one cycle late
            in_ready_reg <= !half_full_reg[nxt_half];
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            dr_g_reg <= '0;
            dr_t_reg <= '0;
            dr_c_reg <= '0;
            dr_half_reg <= 1'b0;
        end else if (dr_take) begin
            // 8 samples by 4 channels per burst
            {dr_g_reg, dr_t_reg, dr_c_reg} <= dr_end ? 11'h000 :
                {dr_g_reg, dr_t_reg, dr_c_reg} + 11'h001;
            dr_half_reg <= dr_half_reg ^ dr_end;
        end
    end

    // rate-change fifo, a write starts only with a whole burst inside
    logic [`SCS_WORD_W-1:0] f_m_data;
    logic f_m_valid;
    logic f_m_ready;
    logic [6:0] f_count;
    logic [`SCS_WORD_W-1:0] f_s_data;

    // upper 16 bits forced to zero
    assign f_s_data = {`SCS_PAD_W'(0),
        ibuf[{dr_half_reg, dr_t_reg, dr_g_reg, dr_c_reg}]};

    scs_rate_fifo #(
        .WIDTH(`SCS_WORD_W),
        .DEPTH(`SCS_FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .sys_rst(sys_rst),
        .s_valid(f_s_valid),
        .s_ready(f_s_ready),
        .s_data(f_s_data),
        .m_valid(f_m_valid),
        .m_ready(f_m_ready),
        .m_data(f_m_data),
        .count(f_count)
    );

    // write address generator state
    logic [5:0] wa_g_reg;
    logic wa_half_reg;
    logic [5:0] wbeats_reg;
    logic mem_wvalid_reg;
    logic [`SCS_WORD_W-1:0] mem_wdata_reg;
    logic [19:0] wa_time;

    assign wa_time = half_time_reg[wa_half_reg];
    assign f_m_ready = wbeats_reg != '0 && (!mem_wvalid_reg || mem_wready);
    assign mem_wvalid = mem_wvalid_reg;
    assign mem_wdata = mem_wdata_reg;

    // read sequencer state
    scs_seq_state_t seq_state_reg;
    logic [19:0] rd_time_reg;
    logic [5:0] rd_g_reg;
    logic [4:0] rd_k_reg;
    logic rd_req_left_reg;
    logic [9:0] rd_word_reg;
    logic [1:0] rd_blk_reg;
    logic load_pkt;
    logic [19:0] load_time;
    logic [5:0] load_g;

    // arbiter and request registers
    logic mem_req_valid_reg;
    logic mem_req_write_reg;
    logic [`SCS_ADDR_W-1:0] mem_req_addr_reg;
    scs_arb_t grant;
    logic [19:0] rd_burst_time;

    assign rd_burst_time = rd_time_reg + {12'h000, rd_k_reg, 3'h0};
    assign mem_req_valid = mem_req_valid_reg;
    assign mem_req_write = mem_req_write_reg;
    assign mem_req_addr = mem_req_addr_reg;
    assign mem_req_len = BURST_LEN;

    always_comb begin
        grant = SCS_ARB_NONE;
        // last write beat must leave before a new request; read beats are not waited for
        if (!mem_req_valid_reg && !mem_wvalid_reg && wbeats_reg == '0) begin
            // writes first: a stalled write path backs up into the input
            if (f_count >= 7'(`SCS_BURST)) begin
                grant = SCS_ARB_WR;
            end else if (rd_req_left_reg) begin
                grant = SCS_ARB_RD;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mem_req_valid_reg <= 1'b0;
            mem_req_write_reg <= 1'b0;
            mem_req_addr_reg <= '0;
        end else if (grant != SCS_ARB_NONE) begin
            mem_req_valid_reg <= 1'b1;
            mem_req_write_reg <= grant == SCS_ARB_WR;
            // region bit, group, 21-bit wrapping time
            if (grant == SCS_ARB_WR) begin
                mem_req_addr_reg <= {wa_time[19], wa_g_reg, wa_time[18:0],
                    2'h0};
            end else begin
                mem_req_addr_reg <= {rd_burst_time[19], rd_g_reg,
                    rd_burst_time[18:0], 2'h0};
            end
        end else if (mem_req_ready) begin
            mem_req_valid_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wa_g_reg <= '0;
            wa_half_reg <= 1'b0;
            wbeats_reg <= '0;
            mem_wvalid_reg <= 1'b0;
            mem_wdata_reg <= '0;
        end else begin
            if (mem_req_valid_reg && mem_req_ready && mem_req_write_reg) begin
                wbeats_reg <= BURST_LEN;
                wa_g_reg <= wa_g_reg == LAST_G ? 6'h00 : wa_g_reg + 6'h01;
                wa_half_reg <= wa_half_reg ^ (wa_g_reg == LAST_G);
            end else if (f_m_ready) begin
                wbeats_reg <= wbeats_reg - 6'h01;
            end
            // the whole burst is in the fifo, so beats never gap
            if (f_m_ready) begin
                mem_wvalid_reg <= 1'b1;
                mem_wdata_reg <= f_m_data;
            end else if (mem_wready) begin
                mem_wvalid_reg <= 1'b0;
            end
        end
    end

    // first-node generator: packet pace, groups, blocks
    logic [PCW-1:0] tick_reg;
    logic [5:0] gen_g_reg;
    logic [19:0] gen_time_reg;
    logic [19:0] blk_start_reg;
    logic [19:0] blk_end_reg;
    logic [1:0] blk_idx_reg;
    logic [19:0] blk_step;
    logic [19:0] ext_samp;
    logic [7:0] ext_frames;
    logic gen_last_g;
    logic gen_blk_end;

    // 2 nf held with 4 fraction bits, rounded up to a whole frame
    assign ext_frames = 8'((9'(preload_x2) + 9'h00f) >> `SCS_PRE_FRAC);
    assign ext_samp = preload_en ? 20'(ext_frames) * 20'(`SCS_CSP_SAMP) :
        20'h00000;
    assign blk_step = 20'(block_frames) * 20'(`SCS_CSP_SAMP);
    assign gen_last_g = gen_g_reg == LAST_G;
    assign gen_blk_end = gen_last_g &&
        gen_time_reg + 20'(`SCS_PKT_SAMP) == blk_end_reg;

    always_comb begin
        load_pkt = 1'b0;
        load_time = pkt_hdr_time;
        load_g = pkt_hdr_group;
        if (seq_state_reg == SCS_SEQ_IDLE) begin
            if (first_node) begin
                // no waiting for incoming packets
                load_pkt = tick_reg == '0;
                load_time = gen_time_reg;
                load_g = gen_g_reg;
            end else begin
                load_pkt = pkt_hdr_valid;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tick_reg <= '0;
        end else if (!first_node || load_pkt) begin
            tick_reg <= PCW'(PKT_PERIOD_CYC - 1);
        end else if (tick_reg != '0) begin
            tick_reg <= tick_reg - 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            gen_g_reg <= '0;
            gen_time_reg <= '0;
            blk_start_reg <= '0;
            blk_end_reg <= 20'(`SCS_BLOCK_DEF) * 20'(`SCS_CSP_SAMP);
            blk_idx_reg <= '0;
        end else if (load_pkt && first_node) begin
            gen_g_reg <= gen_last_g ? 6'h00 : gen_g_reg + 6'h01;
            if (gen_blk_end) begin
                // starts stay one block apart, preload only adds overlap
                blk_start_reg <= blk_start_reg + blk_step;
                gen_time_reg <= blk_start_reg + blk_step - ext_samp;
                blk_end_reg <= blk_start_reg + blk_step + blk_step;
                blk_idx_reg <= blk_idx_reg + 2'h1;
            end else if (gen_last_g) begin
                gen_time_reg <= gen_time_reg + 20'(`SCS_PKT_SAMP);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            seq_state_reg <= SCS_SEQ_IDLE;
            rd_time_reg <= '0;
            rd_g_reg <= '0;
            rd_k_reg <= '0;
            rd_req_left_reg <= 1'b0;
            rd_word_reg <= '0;
            rd_blk_reg <= '0;
            pkt_hdr_ready <= 1'b0;
        end else begin
            pkt_hdr_ready <= seq_state_reg == SCS_SEQ_IDLE && !load_pkt &&
                !first_node;
            unique case (seq_state_reg)
                SCS_SEQ_IDLE: begin
                    if (load_pkt) begin
                        seq_state_reg <= SCS_SEQ_READ;
                        rd_time_reg <= load_time;
                        rd_g_reg <= load_g;
                        rd_k_reg <= '0;
                        rd_req_left_reg <= 1'b1;
                        rd_word_reg <= '0;
                        rd_blk_reg <= blk_idx_reg;
                    end
                end
                SCS_SEQ_READ: begin
                    // one packet: 256 samples by 4 channels
                    if (grant == SCS_ARB_RD) begin
                        rd_k_reg <= rd_k_reg + 5'h01;
                        rd_req_left_reg <= rd_k_reg != LAST_K;
                    end
                    if (mem_rvalid) begin
                        rd_word_reg <= rd_word_reg + 10'h001;
                        if (rd_word_reg == 10'h3ff) begin
                            seq_state_reg <= SCS_SEQ_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // adder: local word plus chain word, both polarizations at once
    logic [`SCS_WORD_W-1:0] sum;
    logic [`SCS_WORD_W-1:0] chain_in;

    assign chain_in = first_node ? '0 : pkt_data;

    always_comb begin
        sum = '0;
        for (int i = 0; i < 4; i++) begin
            sum[i*16 +: 16] = chain_in[i*16 +: 16] +
                {{(`SCS_CHAIN_W-`SCS_IN_W){mem_rdata[i*12+11]}},
                mem_rdata[i*12 +: 12]};
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            out_valid <= 1'b0;
            out_last <= 1'b0;
            out_data <= '0;
            out_q8 <= '0;
            out_time <= '0;
            out_group <= '0;
            out_block_idx <= '0;
        end else begin
            // every word carries one channel sample of its burst, both polarizations
            out_valid <= mem_rvalid && seq_state_reg == SCS_SEQ_READ;
            out_last <= mem_rvalid && rd_word_reg == 10'h3ff;
            if (mem_rvalid) begin
                out_data <= sum;
                for (int i = 0; i < 4; i++) begin
                    // top byte kept, truncation trades accuracy for area
                    out_q8[i*8 +: 8] <= sum[i*16+8 +: 8];
                end
            end
            out_time <= rd_time_reg;
            out_group <= rd_g_reg;
            out_block_idx <= rd_blk_reg;
        end
    end
endmodule : scs_cornerturner

/* File: bench/scs_cornerturner_monitor.sv */
// port assertions for the corner turner
`timescale 1ns/1ps
`include "scs_consts.svh"
module scs_cornerturner_monitor (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // watched ports
    input wire logic in_valid,
    input wire logic in_ready,
    input wire logic mem_req_valid,
    input wire logic mem_req_ready,
    input wire logic mem_req_write,
    input wire logic [`SCS_ADDR_W-1:0] mem_req_addr,
    input wire logic [5:0] mem_req_len,
    input wire logic mem_wvalid,
    input wire logic mem_wready,
    input wire logic [`SCS_WORD_W-1:0] mem_wdata,
    input wire logic mem_rvalid,
    input wire logic out_valid,
    input wire logic out_last,
    input wire logic [`SCS_WORD_W-1:0] out_data,
    input wire logic [31:0] out_q8
);
    logic [5:0] beats_reg;
    logic [9:0] words_reg;
    logic [10:0] taken_reg;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    always_ff @(posedge clk) begin
        if (sys_rst)
            beats_reg <= 6'h00;
        else if (mem_req_valid && mem_req_ready && mem_req_write)
            beats_reg <= 6'h20;
        else if (mem_wvalid && mem_wready)
            beats_reg <= beats_reg - 6'h01;
    end
    always_ff @(posedge clk) begin
        if (sys_rst)
            words_reg <= 10'h000;
        else if (out_valid)
            words_reg <= words_reg + 10'h001;
    end
    always_ff @(posedge clk) begin
        if (sys_rst)
            taken_reg <= 11'h000;
        else if (in_valid && in_ready && taken_reg != 11'h600)
            taken_reg <= taken_reg + 11'h001;
    end
    a_burst_len: assert property (
        mem_req_valid |-> mem_req_len == 6'h20)
        else $error("bad burst length");
    a_write_align: assert property (
        mem_req_valid && mem_req_write |-> mem_req_addr[4:0] == 5'h00)
        else $error("unaligned write");
    a_upper_zero: assert property (
        mem_wvalid |-> mem_wdata[63:48] == 16'h0000)
        else $error("upper bits set");
    a_req_hold: assert property (
        mem_req_valid && !mem_req_ready |=>
        mem_req_valid && $stable(mem_req_addr) && $stable(mem_req_write))
        else $error("request not held");
    a_no_overlap: assert property (
        mem_req_valid |-> beats_reg == 6'h00)
        else $error("request in open burst");
    a_write_owed: assert property (
        mem_wvalid |-> beats_reg != 6'h00)
        else $error("extra write beat");
    a_write_gapless: assert property (
        mem_wvalid && mem_wready && beats_reg > 6'h01 |=> mem_wvalid)
        else $error("write gap");
    a_frames_first: assert property (
        mem_req_valid && mem_req_write |-> taken_reg == 11'h600)
        else $error("write too early");
    a_out_pace: assert property (
        out_valid == $past(mem_rvalid))
        else $error("output pace");
    a_last_word: assert property (
        out_last |-> out_valid && words_reg == 10'h3ff)
        else $error("last flag misplaced");
    a_q8_trunc: assert property (
        out_valid |-> out_q8 == {out_data[63:56], out_data[47:40],
        out_data[31:24], out_data[15:8]})
        else $error("bad q8 bytes");
endmodule : scs_cornerturner_monitor
bind scs_cornerturner scs_cornerturner_monitor
    scs_cornerturner_monitor_i (.*);

/* File: bench/scs_mem_model.sv */
// memory controller model behind the generic request port
`timescale 1ns/1ps
module scs_mem_model (
    // clock, reset and pacing
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic slow,
    // request and data ports
    input wire logic mem_req_valid,
    output logic mem_req_ready,
    input wire logic mem_req_write,
    input wire logic [27:0] mem_req_addr,
    input wire logic mem_wvalid,
    output logic mem_wready,
    input wire logic [63:0] mem_wdata,
    output logic mem_rvalid,
    output logic [63:0] mem_rdata
);
    logic [63:0] mem [int];
    int wq[$];
    int rq[$];
    int wn = 0, rn = 0;
    int wtot = 0;
    logic tick = 1'b0;
    // slow mode stalls every other cycle
    assign mem_req_ready = !slow || tick;
    assign mem_wready = !slow || !tick;
    initial begin
        mem_rvalid = 1'b0;
        mem_rdata = 64'h0;
    end
    always @(posedge clk) begin
        if (mem_req_valid && mem_req_ready && !sys_rst) begin
            if (mem_req_write)
                wq.push_back(int'(mem_req_addr));
            else
                rq.push_back(int'(mem_req_addr));
        end
        if (mem_wvalid && mem_wready && wq.size() > 0) begin
            mem[wq[0] + wn] = mem_wdata;
            wtot++;
            wn++;
            if (wn == 32) begin
                wn = 0;
                void'(wq.pop_front());
            end
        end
        // an idle data bus inverts its word every cycle, never holding the last word
        mem_rvalid <= 1'b0;
        mem_rdata <= ~mem_rdata;
        if (rq.size() > 0 && (!slow || tick)) begin
            mem_rvalid <= 1'b1;
            mem_rdata <= mem.exists(rq[0] + rn) ? mem[rq[0] + rn]
                : 64'(rq[0] + rn);
            rn++;
            if (rn == 32) begin
                rn = 0;
                void'(rq.pop_front());
            end
        end
        if (sys_rst) begin
            wq.delete();
            rq.delete();
            wn = 0;
            rn = 0;
            mem_rvalid <= 1'b0;
        end
        tick <= !tick;
    end
endmodule : scs_mem_model

/* File: bench/test_station_cornerturner_sequencer.sv */
// bench for the corner turner and frame sequencer
`timescale 1ns/1ps
module test_station_cornerturner_sequencer;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic first_node = 1'b1;
    logic slow = 1'b0;
    logic in_valid = 1'b0;
    logic [47:0] in_data = 48'h0;
    logic pkt_hdr_valid = 1'b0;
    logic [5:0] pkt_hdr_group = 6'h00;
    logic [15:0] pkt_n = 16'h0000;
    logic in_ready, mem_req_valid, mem_req_ready, mem_req_write;
    logic mem_wvalid, mem_wready, mem_rvalid, pkt_hdr_ready;
    logic out_valid, out_last;
    logic [27:0] mem_req_addr;
    logic [5:0] mem_req_len, out_group;
    logic [63:0] mem_wdata, mem_rdata, out_data;
    logic [63:0] oq[$];
    logic [27:0] rq[$];
    logic [5:0] gq[$];
    int fail_count = 0;
    int cmp_count = 0;
    int lasts = 0;
    scs_cornerturner #(.PKT_PERIOD_CYC(20)) scs_cornerturner_i (
        .block_frames(10'h066), .preload_en(1'b0), .preload_x2(8'h00),
        .pkt_hdr_time(20'h00000), .pkt_data({4{pkt_n}}), .out_q8(),
        .out_time(), .out_block_idx(), .*);
    scs_mem_model scs_mem_model_i (.*);
    initial begin
        forever #25 clk = ~clk;
    end
    // chain source steps after each read beat
    always @(posedge clk) begin
        if (out_valid) oq.push_back(out_data);
        if (out_valid) gq.push_back(out_group);
        if (out_last) lasts++;
        if (mem_req_valid && mem_req_ready && !mem_req_write)
            rq.push_back(mem_req_addr);
        if (mem_rvalid) #1 pkt_n++;
    end
    function automatic logic [47:0] samp(int t, int c);
        return {12'(t + 1), 12'(c), 12'(t), 12'(c + 3)};
    endfunction : samp
    task automatic check(string what, logic [63:0] exp, logic [63:0] got);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic conclude;
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : conclude
    task automatic test_reset;
        repeat (2) @(posedge clk);
        #1 check("idle outputs", 64'h0, 64'({in_ready, mem_req_valid,
            mem_wvalid, out_valid, pkt_hdr_ready}));
        sys_rst = 1'b0;
        $display("test reset done");
    endtask : test_reset
    task automatic test_write;
        for (int t = 0; t < 8; t++) begin
            for (int c = 0; c < 192; c++) begin
                in_data = samp(t, c);
                in_valid = 1'b1;
                do @(posedge clk); while (!in_ready);
                #1;
            end
        end
        in_valid = 1'b0;
        for (int i = 0; i < 20000 && scs_mem_model_i.wtot < 1536; i++)
            @(posedge clk);
        for (int g = 0; g < 48; g++) begin
            for (int w = 0; w < 32; w++)
                check("stored word", {16'h0, samp(w / 4, 4 * g + w % 4)},
                    scs_mem_model_i.mem[(g << 21) + w]);
        end
        for (int i = 0; i < 20000 && lasts == 0; i++)
            @(posedge clk);
        check("self paced packet", 64'h1, 64'(lasts > 0));
        $display("test write done");
    endtask : test_write
    task automatic test_chain;
        logic [47:0] s;
        logic [63:0] e;
        first_node = 1'b0;
        slow = 1'b1;
        @(posedge clk);
        #1 sys_rst = 1'b1;
        repeat (2) @(posedge clk);
        #1 sys_rst = 1'b0;
        oq.delete();
        gq.delete();
        rq.delete();
        lasts = 0;
        pkt_n = 16'h0000;
        for (int i = 0; i < 20 && !pkt_hdr_ready; i++)
            @(posedge clk);
        #1 pkt_hdr_group = 6'h05;
        pkt_hdr_valid = 1'b1;
        @(posedge clk);
        #1 pkt_hdr_valid = 1'b0;
        repeat (100) @(posedge clk);
        // header mid-read is dropped
        #1 pkt_hdr_group = 6'h09;
        pkt_hdr_valid = 1'b1;
        @(posedge clk);
        #1 pkt_hdr_valid = 1'b0;
        for (int i = 0; i < 20000 && lasts == 0; i++)
            @(posedge clk);
        repeat (300) @(posedge clk);
        check("packet words", 64'd1024, 64'(oq.size()));
        check("first read", 64'(28'h0a00000), 64'(rq[0]));
        check("second read", 64'(28'h0a00020), 64'(rq[1]));
        check("group out", 64'h5, 64'(gq[1023]));
        for (int k = 0; k < 32; k++) begin
            s = samp(k / 4, 20 + k % 4);
            for (int i = 0; i < 4; i++)
                e[16 * i +: 16] = {4'h0, s[12 * i +: 12]} + 16'(k);
            check("summed word", e, oq[k]);
        end
        $display("test chain done");
    endtask : test_chain
    initial begin
        #(50 * 60000);
        fail_count++;
        conclude;
    end
    initial begin
        test_reset;
        test_write;
        test_chain;
        conclude;
    end
endmodule : test_station_cornerturner_sequencer
